/* bench/d2r_core_test.sv */
// self-checking bench for the ddr2 device core
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin errors++; $display("[ERR] t=%0t got=%h exp=%h", $time, (g), (e)); end end
module d2r_core_test;
  logic        clk, rst_b, reg_wr, reg_rd;
  logic [3:0]  reg_addr;
  logic [31:0] reg_wdata;
  wire  [31:0] reg_rdata;
  wire         ck, cke, cs_b, ras_b, cas_b, we_b, dq_oe, dqs_in, dqs_out, dqs_c_out, dqs_oe, dll_on;
  wire  [1:0]  ba;
  wire  [12:0] addr;
  wire  [0:0]  dm;
  wire  [7:0]  dq_in, dq_out;
  int          errors, checks, cyc, al, cl, bl, rl, oe0;
  logic [7:0]  bs, ex;

  d2r_core d2r_core_inst (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ck(ck), .cke(cke), .cs_b(cs_b),
    .ras_b(ras_b), .cas_b(cas_b), .we_b(we_b), .ba(ba), .addr(addr), .dm(dm), .dq_in(dq_in),
    .dq_out(dq_out), .dq_oe(dq_oe), .dqs_in(dqs_in), .dqs_out(dqs_out), .dqs_c_out(dqs_c_out),
    .dqs_oe(dqs_oe), .dll_on(dll_on));
  d2r_ctrl_model d2r_ctrl_model_inst (.clk(clk), .ck(ck), .cke(cke), .cs_b(cs_b), .ras_b(ras_b),
    .cas_b(cas_b), .we_b(we_b), .ba(ba), .addr(addr), .dm(dm), .dq_in(dq_in), .dqs_in(dqs_in),
    .dq_out(dq_out), .dq_oe(dq_oe), .dqs_out(dqs_out), .dqs_c_out(dqs_c_out), .dqs_oe(dqs_oe));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      errors++;
      finish_test();
    end
  end

  function automatic logic [31:0] stat(input logic [3:0] bk, input logic sr, input logic dl, input logic vi);
    stat = 32'h0000_0000;
    stat[d2r_pkg::ST_BANK_LSB +: 4] = bk;
    stat[d2r_pkg::ST_SREF_BIT] = sr;
    stat[d2r_pkg::ST_DLL_BIT] = dl;
    stat[d2r_pkg::ST_VIOL_BIT] = vi;
  endfunction : stat

  function automatic logic [31:0] cfgv(input int a, input int c, input int b8);
    cfgv = 32'h0000_0000;
    cfgv[d2r_pkg::CFG_AL_LSB +: 3] = a[2:0];
    cfgv[d2r_pkg::CFG_CL_LSB +: 3] = c[2:0];
    cfgv[d2r_pkg::CFG_BL8_BIT] = b8[0];
  endfunction : cfgv

  // register port cycles
  task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : reg_write

  task automatic reg_check(input logic [3:0] a, input logic [31:0] e);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    `CHK(reg_rdata, e)
  endtask : reg_check

  task automatic ck_wait(input int n);
    repeat (n) @(posedge ck);
    repeat (4) @(posedge clk);
  endtask : ck_wait

  // reads from column 5 of bank b, chained half a burst apart
  task automatic rd_burst(input int n, input logic ap, input logic [1:0] b);
    d2r_ctrl_model_inst.rd_q.delete();
    for (int i = 0; i < n; i++) begin
      d2r_ctrl_model_inst.cmd(4'b0101, b, {2'b00, ap && i == n - 1, 6'h00, 4'h5}, 1'b1);
      repeat (bl / 2 - 2) @(negedge ck);
    end
    ck_wait(rl + bl);
  endtask : rd_burst

  task automatic finish_test;
    if (errors == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : finish_test

  // main sequence
  initial begin
    {reg_wr, reg_rd} = 2'b00;
    reg_addr = 4'h0;
    reg_wdata = 32'h0000_0000;
    rst_b = 1'b0;
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    reg_write(4'h8, 32'hFFFF_FFFF);
    reg_check(4'h8, 32'h0000_0000);
    reg_check(d2r_pkg::CFG_OFS, cfgv(0, 3, 0));
    reg_check(d2r_pkg::STAT_OFS, stat(4'h0, 1'b0, 1'b1, 1'b0));
    ck_wait(3);
    for (int p = 0; p < 2; p++) begin
      al = p;
      cl = 3 + p;
      bl = 4 << p;
      rl = al + cl;
      bs = (p == 0) ? 8'h30 : 8'h50;
      reg_write(d2r_pkg::CFG_OFS, cfgv(al, cl, p));
      d2r_ctrl_model_inst.cmd(4'b0011, 2'd1, 13'h0000, 1'b1);
      d2r_ctrl_model_inst.wr(2'd1, 4'h4, 2, rl - 1, bl, bs, bl + 1);
      ck_wait(4);
      rd_burst(1, 1'b0, 2'd1);
      `CHK(d2r_ctrl_model_inst.lat_dq, rl)
      `CHK(d2r_ctrl_model_inst.lat_dqs, rl - 1)
      `CHK(d2r_ctrl_model_inst.pre_st, 2'b01)
      `CHK(d2r_ctrl_model_inst.post_dqs, 1'b0)
      `CHK(dq_oe, 1'b0)
      `CHK(d2r_ctrl_model_inst.rd_q.size(), bl)
      for (int k = 0; k < bl; k++) begin
        ex = ((k + 1) % bl == 1) ? bs + 8'h01 : bs + 8'(bl + (k + 1) % bl);
        `CHK(d2r_ctrl_model_inst.rd_q[k], ex)
      end
      reg_check(d2r_pkg::STAT_OFS, stat(4'b0010, 1'b0, 1'b1, 1'b0));
      oe0 = d2r_ctrl_model_inst.oe_rises;
      rd_burst(2, 1'b1, 2'd1);
      `CHK(d2r_ctrl_model_inst.oe_rises, oe0 + 1)
      `CHK(d2r_ctrl_model_inst.rd_q.size(), 2 * bl)
      reg_check(d2r_pkg::STAT_OFS, stat(4'b0000, 1'b0, 1'b1, 1'b0));
      rd_burst(1, 1'b0, 2'd1);
      `CHK(d2r_ctrl_model_inst.oe_rises, oe0 + 1)
      reg_check(d2r_pkg::STAT_OFS, stat(4'b0000, 1'b0, 1'b1, 1'b1));
      reg_write(d2r_pkg::STAT_OFS, 32'h0000_0001 << d2r_pkg::ST_VIOL_BIT);
      reg_check(d2r_pkg::STAT_OFS, stat(4'b0000, 1'b0, 1'b1, 1'b0));
    end
    `CHK(d2r_ctrl_model_inst.bad_c, 0)
    // single, all and idle bank precharge
    for (int b = 0; b < 4; b++) if (b != 1) d2r_ctrl_model_inst.cmd(4'b0011, b[1:0], 13'h0000, 1'b1);
    d2r_ctrl_model_inst.cmd(4'b0010, 2'd2, 13'h0000, 1'b1);
    ck_wait(2);
    reg_check(d2r_pkg::STAT_OFS, stat(4'b1001, 1'b0, 1'b1, 1'b0));
    d2r_ctrl_model_inst.cmd(4'b0010, 2'd2, 13'h0400, 1'b1);
    d2r_ctrl_model_inst.cmd(4'b0010, 2'd1, 13'h0000, 1'b1);
    ck_wait(4);
    reg_check(d2r_pkg::STAT_OFS, stat(4'b0000, 1'b0, 1'b1, 1'b0));
    // self refresh entry, ignored command, exit, early and late read
    d2r_ctrl_model_inst.cmd(4'b0001, 2'd0, 13'h0000, 1'b0);
    d2r_ctrl_model_inst.cmd(4'b0011, 2'd0, 13'h0000, 1'b0);
    ck_wait(2);
    reg_check(d2r_pkg::STAT_OFS, stat(4'b0000, 1'b1, 1'b0, 1'b0));
    `CHK(dll_on, 1'b0)
    d2r_ctrl_model_inst.cmd(4'b0111, 2'd0, 13'h0000, 1'b1);
    ck_wait(2);
    `CHK(dll_on, 1'b1)
    d2r_ctrl_model_inst.cmd(4'b0011, 2'd0, 13'h0000, 1'b1);
    oe0 = d2r_ctrl_model_inst.oe_rises;
    rd_burst(1, 1'b0, 2'd0);
    `CHK(d2r_ctrl_model_inst.oe_rises, oe0)
    reg_check(d2r_pkg::STAT_OFS, stat(4'b0001, 1'b0, 1'b1, 1'b1));
    reg_write(d2r_pkg::STAT_OFS, 32'h0000_0001 << d2r_pkg::ST_VIOL_BIT);
    ck_wait(200);
    rd_burst(1, 1'b0, 2'd0);
    `CHK(d2r_ctrl_model_inst.oe_rises, oe0 + 1)
    reg_check(d2r_pkg::STAT_OFS, stat(4'b0001, 1'b0, 1'b1, 1'b0));
    finish_test();
  end
endmodule : d2r_core_test
`default_nettype wire

/* bench/d2r_ctrl_model.sv */
// controller-side model: link clock, command pins, write strobes and read capture
`timescale 1ns/1ps
`default_nettype none
module d2r_ctrl_model (
  // system clock used to align pin changes
  input  wire logic       clk,
  // link clock and command pins
  output logic            ck,
  output logic            cke,
  output logic            cs_b,
  output logic            ras_b,
  output logic            cas_b,
  output logic            we_b,
  output logic [1:0]      ba,
  output logic [12:0]     addr,
  // resolved write side of the data pins
  output logic [0:0]      dm,
  output logic [7:0]      dq_in,
  output logic            dqs_in,
  // device driven read side
  input  wire logic [7:0] dq_out,
  input  wire logic       dq_oe,
  input  wire logic       dqs_out,
  input  wire logic       dqs_c_out,
  input  wire logic       dqs_oe
);
  logic [7:0] dq_m;
  logic       dqs_m, dq_e, dqs_e, p_oe, p_soe, p_dqs, post_dqs;
  logic [1:0] pre_st;
  logic [7:0] rd_q[$];
  int         rises, cmd_rise, lat_dq, lat_dqs, oe_rises, bad_c;

  // released lines show the inverse of their last value
  assign dq_in  = dq_oe ? dq_out : (dq_e ? dq_m : ~dq_m);
  assign dqs_in = dqs_oe ? dqs_out : (dqs_e ? dqs_m : ~dqs_m);

  // free running link clock, phase offset from clk
  initial begin
    ck = 1'b0;
    cke = 1'b1;
    {cs_b, ras_b, cas_b, we_b} = 4'b0111;
    ba = 2'b00;
    addr = 13'h0000;
    {dm, dq_m, dqs_m, dq_e, dqs_e} = '0;
    #3;
    forever #80 ck = ~ck;
  end

  always @(posedge ck) rises <= rises + 1;

  // one command held a full link period around its rise
  task automatic cmd(input logic [3:0] c, input logic [1:0] b, input logic [12:0] a, input logic k);
    @(negedge ck);
    @(posedge clk);
    {cs_b, ras_b, cas_b, we_b} <= c;
    cke <= k;
    ba <= b;
    addr <= a;
    cmd_rise <= rises + 1;
    @(negedge ck);
    @(posedge clk);
    {cs_b, ras_b, cas_b, we_b} <= 4'b0111;
    ba <= ~b;
    addr <= ~a;
  endtask : cmd

  // write bursts chained half a burst apart, beat k carries base+k, beat mk masked
  task automatic wr(input logic [1:0] b, input logic [3:0] col, input int n, input int wl, input int bl,
                    input logic [7:0] base, input int mk);
    fork
      for (int i = 0; i < n; i++) begin
        cmd(4'b0100, b, {9'h000, col}, 1'b1);
        repeat (bl / 2 - 2) @(negedge ck);
      end
      begin
        @(negedge ck);
        @(posedge clk);
        dqs_e <= 1'b1;
        dqs_m <= 1'b0;
        dq_e <= 1'b1;
        repeat (wl) @(posedge ck);
        @(negedge ck);
        for (int k = 0; k < n * bl; k++) begin
          #40;
          @(posedge clk);
          dq_m <= base + k[7:0];
          dm <= (k == mk);
          @(ck);
          @(posedge clk);
          dqs_m <= ~dqs_m;
        end
        @(ck);
        @(posedge clk);
        dqs_e <= 1'b0;
        dq_e <= 1'b0;
      end
    join
  endtask : wr

  // collect read beats on strobe changes, note latencies and strobe states
  always @(posedge clk) begin
    p_oe <= dq_oe;
    p_soe <= dqs_oe;
    p_dqs <= dqs_out;
    if (dqs_oe && !p_soe) begin
      lat_dqs <= rises - cmd_rise;
      pre_st <= {dqs_out, dqs_c_out};
    end
    if (dq_oe && !p_oe) begin
      lat_dq <= rises - cmd_rise;
      oe_rises <= oe_rises + 1;
    end
    if (dq_oe && (!p_oe || dqs_out != p_dqs)) rd_q.push_back(dq_out);
    if (!dq_oe && p_oe) post_dqs <= p_dqs;
    if (dqs_oe && dqs_c_out !== ~dqs_out) bad_c <= bad_c + 1;
  end
endmodule : d2r_ctrl_model
`default_nettype wire

/* pkg/d2r_pkg.sv */
// constants and types for the ddr2 read, write, precharge and self refresh device core
`default_nettype none
package d2r_pkg;
  // register offsets on the plain register port
  localparam logic [3:0] CFG_OFS       = 4'h0;
  localparam logic [3:0] STAT_OFS      = 4'h4;
  // config register fields
  localparam int         CFG_AL_LSB    = 0;
  localparam int         CFG_CL_LSB    = 3;
  localparam int         CFG_BL8_BIT   = 6;
  // config reset values
  localparam logic [2:0] AL_RST        = 3'h0;
  localparam logic [2:0] CL_RST        = 3'h3;
  localparam logic       BL8_RST       = 1'b0;
  // status register fields
  localparam int         ST_BANK_LSB   = 0;
  localparam int         ST_SREF_BIT   = 4;
  localparam int         ST_DLL_BIT    = 5;
  localparam int         ST_VIOL_BIT   = 6;
  localparam int         ST_RDBUSY_BIT = 7;
  // link clock cycles after self refresh exit before a read
  localparam logic [7:0] SREF_EXIT_CK  = 8'hC8;
  // decoded commands
  typedef enum logic [2:0] {
    C_NOP = 3'b000,
    C_ACT = 3'b001,
    C_RD  = 3'b010,
    C_WR  = 3'b011,
    C_PRE = 3'b100,
    C_REF = 3'b101,
    C_MRS = 3'b110
  } d2r_cmd_type;
  // read output state
  typedef enum logic [1:0] {
    RD_IDLE  = 2'b00,
    RD_PRE   = 2'b01,
    RD_BURST = 2'b10
  } d2r_rd_type;
endpackage : d2r_pkg
`default_nettype wire

/* rtl/d2r_core.sv */
// ddr2 device core: read and write bursts, precharge, self refresh
//
// Implementation choices: the address map and strobed register access.
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// R1 - first read beat after additive plus cas latency
// R2 - further read beats on every clock crossing
// R3 - strobe low preamble, low with last beat
// R4 - outputs released when burst ends unchained
// R5 - controller chains reads half burst apart
// R6 - address ten selects auto precharge
// R7 - write uses bank pins and column bits
// R8 - mask high leaves byte unchanged
// R9 - write latency is read latency minus one
// R10 - capture on strobe edges, ignore extras
// R11 - controller gives write strobe pre/postamble
// R12 - controller chains writes half burst apart
// R13 - controller never truncates short writes
// R14 - controller waits write-to-read time
// R15 - precharge closes rows, banks go idle
// R16 - address ten high precharges every bank
// R17 - precharge to idle bank is accepted
// R18 - controller waits precharge time before activate
// R19 - refresh with clock enable low enters
// R20 - controller keeps clock stable around entry
// R21 - only idle commands during exit time
// R22 - dll back on, reads wait 200 clocks
// R23 - commands decoded at rising link clock
// R24 - self refresh exit seen without clock
// R25 - track banks, reject access to idle
module d2r_core #(
  parameter int DQ_W  = 8,
  parameter int DM_W  = 1,
  parameter int COL_W = 4,
  parameter int PD    = 16
) (
  // system clock and reset
  input  wire  logic              clk,
  input  wire  logic              rst_b,
  // register port
  input  wire  logic [3:0]        reg_addr,
  input  wire  logic [31:0]       reg_wdata,
  input  wire  logic              reg_wr,
  input  wire  logic              reg_rd,
  output logic       [31:0]       reg_rdata,
  // command and address pins
  input  wire  logic              ck,
  input  wire  logic              cke,
  input  wire  logic              cs_b,
  input  wire  logic              ras_b,
  input  wire  logic              cas_b,
  input  wire  logic              we_b,
  input  wire  logic [1:0]        ba,
  input  wire  logic [12:0]       addr,
  // data pins
  input  wire  logic [DM_W-1:0]   dm,
  input  wire  logic [DQ_W-1:0]   dq_in,
  output logic       [DQ_W-1:0]   dq_out,
  output logic                    dq_oe,
  input  wire  logic              dqs_in,
  output logic                    dqs_out,
  output logic                    dqs_c_out,
  output logic                    dqs_oe,
  // delay locked loop state
  output logic                    dll_on
);
  localparam int SW = 22 + DM_W + DQ_W; // six command bits, bank, address, strobe, mask, data
  localparam int MW = 2 + COL_W;

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic [SW-1:0] s1_r, s2_r;
  logic ck_d_r, dqs_d_r;
  logic s_ck, s_cke, s_cs_b, s_ras_b, s_cas_b, s_we_b, s_dqs;
  logic [1:0] s_ba;
  logic [12:0] s_addr;
  logic [DM_W-1:0] s_dm;
  logic [DQ_W-1:0] s_dq;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s1_r    <= '0;
      s2_r    <= '0;
      ck_d_r  <= 1'b0;
      dqs_d_r <= 1'b0;
    end else begin
      s1_r    <= {ck, cke, cs_b, ras_b, cas_b, we_b, ba, addr, dqs_in, dm, dq_in};
      s2_r    <= s1_r;
      ck_d_r  <= s_ck;
      dqs_d_r <= s_dqs;
    end
  end
  assign {s_ck, s_cke, s_cs_b, s_ras_b, s_cas_b, s_we_b, s_ba, s_addr, s_dqs, s_dm, s_dq} = s2_r;

  // edges of the sampled link clock and strobe
  logic ck_rise, ck_edge, dqs_rise, dqs_edge;
  assign ck_rise  = s_ck & ~ck_d_r; // R23
  assign ck_edge  = s_ck ^ ck_d_r;
  assign dqs_rise = s_dqs & ~dqs_d_r;
  assign dqs_edge = s_dqs ^ dqs_d_r;

  ////////////////////////////////////////////////////////////////////////
  // decoding helpers
  function automatic d2r_pkg::d2r_cmd_type decode(input logic cs, input logic ras, input logic cas,
                                                  input logic we);
    if (cs) return d2r_pkg::C_NOP;
    case ({ras, cas, we})
      3'b011:  return d2r_pkg::C_ACT;
      3'b101:  return d2r_pkg::C_RD;
      3'b100:  return d2r_pkg::C_WR;
      3'b010:  return d2r_pkg::C_PRE;
      3'b001:  return d2r_pkg::C_REF;
      3'b000:  return d2r_pkg::C_MRS;
      default: return d2r_pkg::C_NOP;
    endcase
  endfunction : decode

  // column of a beat, wrapping inside the burst
  function automatic logic [COL_W-1:0] beat_col(input logic [COL_W-1:0] c, input logic [2:0] b,
                                                input logic bl8);
    if (bl8) return {c[COL_W-1:3], 3'(c[2:0] + b)};
    return {c[COL_W-1:2], 2'(c[1:0] + b[1:0])};
  endfunction : beat_col

  d2r_pkg::d2r_cmd_type cmd;
  assign cmd = decode(s_cs_b, s_ras_b, s_cas_b, s_we_b); // R23

  ////////////////////////////////////////////////////////////////////////
  // state
  logic [6:0]       cfg_r, cfg_nxt;
  logic             viol_r, viol_nxt;
  logic [31:0]      rdata_r, rdata_nxt;
  logic [3:0]       open_r, open_nxt;
  logic             sref_r, sref_nxt, dll_r, dll_nxt, ckep_r, ckep_nxt;
  logic [7:0]       xs_r, xs_nxt;
  logic [PD-1:0]    pv_r, pv_nxt, pa_r, pa_nxt;
  logic [1:0]       pb_r [PD], pb_nxt [PD];
  logic [COL_W-1:0] pc_r [PD], pc_nxt [PD];
  d2r_pkg::d2r_rd_type rst_r, rst_nxt;
  logic [1:0]       rb_r, rb_nxt;
  logic [COL_W-1:0] rc_r, rc_nxt;
  logic             ra_r, ra_nxt;
  logic [2:0]       rbt_r, rbt_nxt;
  logic [DQ_W-1:0]  dq_r, dq_nxt;
  logic             dqoe_r, dqoe_nxt, dqs_r, dqs_nxt, dqsc_r, dqsc_nxt, dqsoe_r, dqsoe_nxt;
  logic             wact_r, wact_nxt, warm_r, warm_nxt, wa_r, wa_nxt;
  logic [1:0]       wb_r, wb_nxt;
  logic [COL_W-1:0] wc_r, wc_nxt;
  logic [2:0]       wbt_r, wbt_nxt;
  logic [3:0]       wwait_r, wwait_nxt;
  logic             qv_r, qv_nxt, qa_r, qa_nxt;
  logic [1:0]       qb_r, qb_nxt;
  logic [COL_W-1:0] qc_r, qc_nxt;
  // combinational helpers
  logic             viol_set, rd_acc, wr_acc, consumed, mem_we;
  logic [MW-1:0]    widx;
  logic [3:0]       rl, wl;
  logic [2:0]       last_beat;
  logic             bl8;
  logic [DQ_W-1:0]  mem [0:(1<<MW)-1];

  assign bl8       = cfg_r[d2r_pkg::CFG_BL8_BIT];
  assign rl        = {1'b0, cfg_r[d2r_pkg::CFG_AL_LSB +: 3]} + {1'b0, cfg_r[d2r_pkg::CFG_CL_LSB +: 3]}; // R1
  assign wl        = rl - 4'h1; // R9
  assign last_beat = bl8 ? 3'h7 : 3'h3;

  ////////////////////////////////////////////////////////////////////////
  // next state of commands, read path, write path and registers
  always_comb begin
    cfg_nxt = cfg_r; viol_nxt = viol_r; rdata_nxt = 32'h0000_0000; open_nxt = open_r;
    sref_nxt = sref_r; dll_nxt = dll_r; ckep_nxt = ckep_r; xs_nxt = xs_r;
    pv_nxt = pv_r; pa_nxt = pa_r; pb_nxt = pb_r; pc_nxt = pc_r;
    rst_nxt = rst_r; rb_nxt = rb_r; rc_nxt = rc_r; ra_nxt = ra_r; rbt_nxt = rbt_r;
    dq_nxt = dq_r; dqoe_nxt = dqoe_r; dqs_nxt = dqs_r; dqsc_nxt = dqsc_r; dqsoe_nxt = dqsoe_r;
    wact_nxt = wact_r; warm_nxt = warm_r; wa_nxt = wa_r; wb_nxt = wb_r; wc_nxt = wc_r;
    wbt_nxt = wbt_r; wwait_nxt = wwait_r;
    qv_nxt = qv_r; qa_nxt = qa_r; qb_nxt = qb_r; qc_nxt = qc_r;
    viol_set = 1'b0; rd_acc = 1'b0; wr_acc = 1'b0; consumed = 1'b0; mem_we = 1'b0; widx = '0;
    // command decode and self refresh
    if (sref_r) begin
      if (s_cke) begin // R24
        sref_nxt = 1'b0;
        dll_nxt  = 1'b1; // R22
        xs_nxt   = d2r_pkg::SREF_EXIT_CK;
        ckep_nxt = 1'b1;
      end
    end else if (ck_rise) begin
      ckep_nxt = s_cke;
      if (xs_r != 8'h00) xs_nxt = xs_r - 8'h01;
      if (xs_r != 8'h00 && cmd != d2r_pkg::C_NOP) viol_set = 1'b1;
      if (ckep_r && !s_cke && cmd == d2r_pkg::C_REF) begin // R19
        sref_nxt = 1'b1;
        dll_nxt  = 1'b0;
      end else if (ckep_r) begin
        case (cmd)
          d2r_pkg::C_ACT: open_nxt[s_ba] = 1'b1;
          d2r_pkg::C_PRE: begin // R15 R17
            if (s_addr[10]) open_nxt = 4'h0; // R16
            else open_nxt[s_ba] = 1'b0;
          end
          d2r_pkg::C_RD: begin
            if (!open_r[s_ba] || xs_r != 8'h00) viol_set = 1'b1; // R25 R22
            else rd_acc = 1'b1;
          end
          d2r_pkg::C_WR: begin
            if (!open_r[s_ba]) viol_set = 1'b1; // R25
            else wr_acc = 1'b1;
          end
          default: ;
        endcase
      end
    end
    // read latency pipeline, one slot per link clock
    if (ck_rise) begin
      consumed = pv_r[0];
      for (int i = 0; i < PD - 1; i++) begin
        pv_nxt[i] = pv_r[i+1]; pa_nxt[i] = pa_r[i+1]; pb_nxt[i] = pb_r[i+1]; pc_nxt[i] = pc_r[i+1];
      end
      pv_nxt[PD-1] = 1'b0;
      if (rd_acc) begin // R1
        pv_nxt[rl-4'h1] = 1'b1;
        pa_nxt[rl-4'h1] = s_addr[10]; // R6
        pb_nxt[rl-4'h1] = s_ba;
        pc_nxt[rl-4'h1] = s_addr[COL_W-1:0];
      end
    end
    // read output sequencing
    case (rst_r)
      d2r_pkg::RD_IDLE: begin
        if (ck_rise && pv_nxt[0]) begin // R3
          rst_nxt = d2r_pkg::RD_PRE; dqsoe_nxt = 1'b1; dqs_nxt = 1'b0; dqsc_nxt = 1'b1;
        end
      end
      d2r_pkg::RD_PRE: begin
        if (ck_rise && consumed) begin // R1
          rst_nxt = d2r_pkg::RD_BURST; rb_nxt = pb_r[0]; rc_nxt = pc_r[0]; ra_nxt = pa_r[0];
          rbt_nxt = 3'h0; dqoe_nxt = 1'b1; dqs_nxt = 1'b1; dqsc_nxt = 1'b0;
          dq_nxt = mem[{pb_r[0], pc_r[0]}];
        end
      end
      d2r_pkg::RD_BURST: begin
        if (ck_edge) begin
          if (rbt_r == last_beat) begin
            if (ra_r) open_nxt[rb_r] = 1'b0; // R6
            if (ck_rise && consumed) begin // chained burst follows directly
              rb_nxt = pb_r[0]; rc_nxt = pc_r[0]; ra_nxt = pa_r[0]; rbt_nxt = 3'h0;
              dqs_nxt = 1'b1; dqsc_nxt = 1'b0; dq_nxt = mem[{pb_r[0], pc_r[0]}];
            end else if (pv_nxt[0]) begin
              rst_nxt = d2r_pkg::RD_PRE; dqoe_nxt = 1'b0; dqs_nxt = 1'b0; dqsc_nxt = 1'b1;
            end else begin // R4
              rst_nxt = d2r_pkg::RD_IDLE; dqoe_nxt = 1'b0; dqsoe_nxt = 1'b0;
              dqs_nxt = 1'b0; dqsc_nxt = 1'b0;
            end
          end else begin // R2 R3
            rbt_nxt = rbt_r + 3'h1; dqs_nxt = rbt_r[0]; dqsc_nxt = ~rbt_r[0];
            dq_nxt = mem[{rb_r, beat_col(rc_r, rbt_r + 3'h1, bl8)}];
          end
        end
      end
      default: rst_nxt = d2r_pkg::RD_IDLE;
    endcase
    // write strobe capture
    if (ck_rise && wwait_r != 4'h0) wwait_nxt = wwait_r - 4'h1;
    if (wact_r && rst_r == d2r_pkg::RD_IDLE) begin
      if ((!warm_r && dqs_rise && wwait_r == 4'h0) || (warm_r && dqs_edge)) begin // R10 R9
        mem_we = 1'b1;
        widx = {wb_r, beat_col(wc_r, warm_r ? wbt_r : 3'h0, bl8)};
        warm_nxt = 1'b1;
        wbt_nxt = warm_r ? wbt_r + 3'h1 : 3'h1;
        if ((warm_r ? wbt_r : 3'h0) == last_beat) begin
          if (wa_r) open_nxt[wb_r] = 1'b0; // R6
          warm_nxt = 1'b0; wact_nxt = qv_r; qv_nxt = 1'b0; wwait_nxt = 4'h0;
          wb_nxt = qb_r; wc_nxt = qc_r; wa_nxt = qa_r;
        end
      end
    end
    if (wr_acc) begin // R7
      if (!wact_nxt) begin
        wact_nxt = 1'b1; warm_nxt = 1'b0; wwait_nxt = wl - 4'h1; // R9
        wb_nxt = s_ba; wc_nxt = s_addr[COL_W-1:0]; wa_nxt = s_addr[10];
      end else begin
        qv_nxt = 1'b1; qb_nxt = s_ba; qc_nxt = s_addr[COL_W-1:0]; qa_nxt = s_addr[10];
      end
    end
    // register port
    if (reg_wr && reg_addr == d2r_pkg::CFG_OFS) cfg_nxt = reg_wdata[6:0];
    if (reg_wr && reg_addr == d2r_pkg::STAT_OFS && reg_wdata[d2r_pkg::ST_VIOL_BIT]) viol_nxt = 1'b0;
    if (viol_set) viol_nxt = 1'b1; // set wins over clear
    if (reg_rd && reg_addr == d2r_pkg::CFG_OFS) rdata_nxt = {25'h0, cfg_r};
    if (reg_rd && reg_addr == d2r_pkg::STAT_OFS) begin
      rdata_nxt[d2r_pkg::ST_BANK_LSB +: 4] = open_r;
      rdata_nxt[d2r_pkg::ST_SREF_BIT]      = sref_r;
      rdata_nxt[d2r_pkg::ST_DLL_BIT]       = dll_r;
      rdata_nxt[d2r_pkg::ST_VIOL_BIT]      = viol_r;
      rdata_nxt[d2r_pkg::ST_RDBUSY_BIT]    = rst_r != d2r_pkg::RD_IDLE;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // state registers
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cfg_r <= {d2r_pkg::BL8_RST, d2r_pkg::CL_RST, d2r_pkg::AL_RST};
      viol_r <= 1'b0; rdata_r <= 32'h0000_0000; open_r <= 4'h0;
      sref_r <= 1'b0; dll_r <= 1'b1; ckep_r <= 1'b0; xs_r <= 8'h00;
      pv_r <= '0; pa_r <= '0;
      for (int i = 0; i < PD; i++) begin
        pb_r[i] <= 2'h0;
        pc_r[i] <= '0;
      end
      rst_r <= d2r_pkg::RD_IDLE; rb_r <= 2'h0; rc_r <= '0; ra_r <= 1'b0; rbt_r <= 3'h0;
      dq_r <= '0; dqoe_r <= 1'b0; dqs_r <= 1'b0; dqsc_r <= 1'b0; dqsoe_r <= 1'b0;
      wact_r <= 1'b0; warm_r <= 1'b0; wa_r <= 1'b0; wb_r <= 2'h0; wc_r <= '0;
      wbt_r <= 3'h0; wwait_r <= 4'h0;
      qv_r <= 1'b0; qa_r <= 1'b0; qb_r <= 2'h0; qc_r <= '0;
    end else begin
      cfg_r <= cfg_nxt; viol_r <= viol_nxt; rdata_r <= rdata_nxt; open_r <= open_nxt;
      sref_r <= sref_nxt; dll_r <= dll_nxt; ckep_r <= ckep_nxt; xs_r <= xs_nxt;
      pv_r <= pv_nxt; pa_r <= pa_nxt; pb_r <= pb_nxt; pc_r <= pc_nxt;
      rst_r <= rst_nxt; rb_r <= rb_nxt; rc_r <= rc_nxt; ra_r <= ra_nxt; rbt_r <= rbt_nxt;
      dq_r <= dq_nxt; dqoe_r <= dqoe_nxt; dqs_r <= dqs_nxt; dqsc_r <= dqsc_nxt; dqsoe_r <= dqsoe_nxt;
      wact_r <= wact_nxt; warm_r <= warm_nxt; wa_r <= wa_nxt; wb_r <= wb_nxt; wc_r <= wc_nxt;
      wbt_r <= wbt_nxt; wwait_r <= wwait_nxt;
      qv_r <= qv_nxt; qa_r <= qa_nxt; qb_r <= qb_nxt; qc_r <= qc_nxt;
    end
  end

  // array write, one byte lane per mask bit
  always_ff @(posedge clk) begin
    for (int i = 0; i < DM_W; i++) begin
      if (mem_we && !s_dm[i]) mem[widx][8*i +: 8] <= s_dq[8*i +: 8]; // R8
    end
  end

  assign reg_rdata = rdata_r;
  assign dq_out    = dq_r;
  assign dq_oe     = dqoe_r;
  assign dqs_out   = dqs_r;
  assign dqs_c_out = dqsc_r;
  assign dqs_oe    = dqsoe_r;
  assign dll_on    = dll_r;

  ////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  chk_read_first_beat: assert property (ck_rise && pv_r[0] |=> rst_r == d2r_pkg::RD_BURST && dq_oe && rbt_r == 3'h0) // R1
    else $error("read burst did not start at latency");
  chk_beat_advance: assert property (rst_r == d2r_pkg::RD_BURST && ck_edge && rbt_r != last_beat // R2
    |=> rbt_r == $past(rbt_r) + 3'h1 && dqs_out == ~rbt_r[0])
    else $error("read beat did not advance on clock crossing");
  chk_preamble_low: assert property (rst_r == d2r_pkg::RD_PRE |-> dqs_oe && !dqs_out && dqs_c_out && !dq_oe) // R3
    else $error("read preamble not low");
  chk_release_hiz: assert property (rst_r == d2r_pkg::RD_IDLE |-> !dq_oe && !dqs_oe) // R4
    else $error("outputs driven with no burst");
  chk_idle_bank_rej: assert property (ck_rise && !sref_r && ckep_r && s_cke && cmd == d2r_pkg::C_RD // R25
    && !open_r[s_ba] |=> viol_r && !pv_r[rl-4'h1])
    else $error("read to idle bank not flagged");
  chk_pre_all: assert property (ck_rise && !sref_r && ckep_r && cmd == d2r_pkg::C_PRE && s_addr[10] // R16
    |=> open_r == 4'h0)
    else $error("all bank precharge left a bank open");
  chk_sref_entry: assert property (ck_rise && !sref_r && ckep_r && !s_cke && cmd == d2r_pkg::C_REF // R19
    |=> sref_r && !dll_on)
    else $error("self refresh entry missed");
  chk_sref_exit: assert property (sref_r && s_cke |=> !sref_r && dll_on && xs_r == d2r_pkg::SREF_EXIT_CK) // R24
    else $error("self refresh exit not immediate");
  chk_write_ignored: assert property (!wact_r || rst_r != d2r_pkg::RD_IDLE |-> !mem_we) // R10
    else $error("array written outside a write burst");
  chk_exit_read_wait: assert property (ck_rise && !sref_r && xs_r != 8'h00 && cmd == d2r_pkg::C_RD // R22
    |=> viol_r)
    else $error("read during exit wait not flagged");
endmodule : d2r_core
`default_nettype wire
